// file: common/csdoc_pkg.sv
package csdoc_pkg;
   // ------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------
   localparam logic [7:0] ADDR_FB_DIV_VP   = 8'h3D;
   localparam logic [7:0] ADDR_FB_DIV_N    = 8'h3E;
   localparam logic [7:0] ADDR_OSC_BIAS    = 8'h3F;
   localparam logic [7:0] ADDR_LANE_PE     = 8'h48;
   localparam logic [7:0] ADDR_DIFF_SWING  = 8'h50;

   localparam logic [7:0] RST_FB_DIV_VP    = 8'h00;
   localparam logic [7:0] RST_FB_DIV_N     = 8'h20;
   localparam logic [7:0] RST_OSC_BIAS     = 8'h4F;
   localparam logic [7:0] RST_LANE_PE      = 8'h00;
   localparam logic [7:0] RST_DIFF_SWING   = 8'h00;

   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int P_DIV_LSB   = 2;
   localparam int V_DIV_LSB   = 0;
   localparam int N_DIV_LSB   = 0;
   localparam int BIAS_LSB    = 0;
   localparam int PE_LSB      = 0;
   localparam int SWING_LSB   = 0;

   // Recommended oscillator bias while the synthesizer is in use
   localparam logic [6:0] OSC_BIAS_IN_USE = 7'h4A;

   // Divider ratios decoded from the select codes
   localparam logic [2:0] V_RATIO_CODE0 = 3'h5;
   localparam logic [2:0] V_RATIO_CODE1 = 3'h4;
   localparam logic [2:0] V_RATIO_CODE2 = 3'h3;
   localparam logic [2:0] P_RATIO_CODE0 = 3'h1;
   localparam logic [2:0] P_RATIO_CODE1 = 3'h2;
   localparam logic [2:0] P_RATIO_CODE2 = 3'h4;
   localparam logic [2:0] RATIO_NONE    = 3'h0;
endpackage

// file: rtl/csdoc_ratio_decode.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Select codes to divider ratios, zero for a reserved code
// ------------------------------------------------------------
module csdoc_ratio_decode (
   input  wire logic [1:0] vSel,
   input  wire logic [1:0] pSel,
   input  wire logic [5:0] nSel,
   output logic      [2:0] vRatio,
   output logic      [2:0] pRatio,
   output logic      [5:0] nRatio,
   output logic            selReserved
);
   always_comb begin
      case (vSel)
         2'h0:    vRatio = csdoc_pkg::V_RATIO_CODE0;
         2'h1:    vRatio = csdoc_pkg::V_RATIO_CODE1;
         2'h2:    vRatio = csdoc_pkg::V_RATIO_CODE2;
         default: vRatio = csdoc_pkg::RATIO_NONE;
      endcase
      case (pSel)
         2'h0:    pRatio = csdoc_pkg::P_RATIO_CODE0;
         2'h1:    pRatio = csdoc_pkg::P_RATIO_CODE1;
         2'h2:    pRatio = csdoc_pkg::P_RATIO_CODE2;
         default: pRatio = csdoc_pkg::RATIO_NONE;
      endcase
      // Zero is not a legal N ratio
      nRatio      = nSel;
      selReserved = (vSel == 2'h3) || (pSel == 2'h3) || (nSel == 6'h00);
   end
endmodule

// file: rtl/csdoc_cfg_regs.sv
`timescale 1ns/1ps
// How it works
// - Second-stage divider select bits 3:2: codes 0,1,2 give /1,/2,/4; 3 reserved.
// - First-stage divider select bits 1:0: codes 0,1,2 give /5,/4,/3; 3 reserved.
// - First-stage output feeds second stage; second-stage output is the sampling clock.
// - Third divider ratio is bits 5:0, 1 to 63, reset 0x20.
// - Third divider turns the sampling clock into the detector feedback clock.
// - Four-bit pre-emphasis at bits 3:0, reset zero, shared by every lane.
// - Two-bit swing select at bits 1:0 for reference and trigger outputs, reset 0.
module csdoc_cfg_regs (
   input  wire logic       mclk,
   input  wire logic       rst_n,
   input  wire logic       regWrEn,
   input  wire logic [7:0] regAddr,
   input  wire logic [7:0] regWrData,
   input  wire logic       synthPllReset,
   output logic      [7:0] regRdData,
   output logic            regHit,
   output logic      [1:0] vDivSel,
   output logic      [1:0] pDivSel,
   output logic      [5:0] nDivSel,
   output logic      [2:0] vDivRatio,
   output logic      [2:0] pDivRatio,
   output logic      [5:0] nDivRatio,
   output logic      [8:0] samplingRatio,
   output logic            divSelReserved,
   output logic            divChangedLive,
   output logic      [6:0] oscillatorBiasLevel,
   output logic            biasNotRecommended,
   output logic      [3:0] lanePreemphasis,
   output logic      [1:0] outputSwingSel,
   output logic            highSwingSetting
);
   // ------------------------------------------------------------
   // Register storage
   // ------------------------------------------------------------
   logic [7:0] fbDivVp_reg;
   logic [7:0] fbDivVp_next;
   logic [7:0] fbDivN_reg;
   logic [7:0] fbDivN_next;
   logic [7:0] oscBias_reg;
   logic [7:0] oscBias_next;
   logic [7:0] lanePe_reg;
   logic [7:0] lanePe_next;
   logic [7:0] diffSwing_reg;
   logic [7:0] diffSwing_next;
   logic [7:0] rdData_reg;
   logic [7:0] rdData_next;
   logic       divLive_reg;
   logic       divLive_next;

   function automatic logic addrHit(input logic [7:0] a);
      addrHit = (a == csdoc_pkg::ADDR_FB_DIV_VP) || (a == csdoc_pkg::ADDR_FB_DIV_N)
              || (a == csdoc_pkg::ADDR_OSC_BIAS) || (a == csdoc_pkg::ADDR_LANE_PE)
              || (a == csdoc_pkg::ADDR_DIFF_SWING);
   endfunction

   always_comb begin
      fbDivVp_next   = fbDivVp_reg;
      fbDivN_next    = fbDivN_reg;
      oscBias_next   = oscBias_reg;
      lanePe_next    = lanePe_reg;
      diffSwing_next = diffSwing_reg;
      divLive_next   = divLive_reg;
      if (regWrEn) begin
         // Whole byte stored, reserved bits too, so readback is exact
         case (regAddr)
            csdoc_pkg::ADDR_FB_DIV_VP:  fbDivVp_next   = regWrData;
            csdoc_pkg::ADDR_FB_DIV_N:   fbDivN_next    = regWrData;
            csdoc_pkg::ADDR_OSC_BIAS:   oscBias_next   = regWrData;
            csdoc_pkg::ADDR_LANE_PE:    lanePe_next    = regWrData;
            csdoc_pkg::ADDR_DIFF_SWING: diffSwing_next = regWrData;
            default:                    divLive_next   = divLive_reg;
         endcase
         // Flag a divider change made while the synthesizer was not held in reset
         if ((regAddr == csdoc_pkg::ADDR_FB_DIV_VP || regAddr == csdoc_pkg::ADDR_FB_DIV_N)
             && !synthPllReset) begin
            divLive_next = 1'b1;
         end
      end
      if (synthPllReset) begin
         divLive_next = 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Read path, unmapped addresses read zero
   // ------------------------------------------------------------
   always_comb begin
      case (regAddr)
         csdoc_pkg::ADDR_FB_DIV_VP:  rdData_next = fbDivVp_reg;
         csdoc_pkg::ADDR_FB_DIV_N:   rdData_next = fbDivN_reg;
         csdoc_pkg::ADDR_OSC_BIAS:   rdData_next = oscBias_reg;
         csdoc_pkg::ADDR_LANE_PE:    rdData_next = lanePe_reg;
         csdoc_pkg::ADDR_DIFF_SWING: rdData_next = diffSwing_reg;
         default:                    rdData_next = 8'h00;
      endcase
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         fbDivVp_reg   <= csdoc_pkg::RST_FB_DIV_VP;
         fbDivN_reg    <= csdoc_pkg::RST_FB_DIV_N;
         oscBias_reg   <= csdoc_pkg::RST_OSC_BIAS;
         lanePe_reg    <= csdoc_pkg::RST_LANE_PE;
         diffSwing_reg <= csdoc_pkg::RST_DIFF_SWING;
         rdData_reg    <= 8'h00;
         divLive_reg   <= 1'b0;
      end else begin
         fbDivVp_reg   <= fbDivVp_next;
         fbDivN_reg    <= fbDivN_next;
         oscBias_reg   <= oscBias_next;
         lanePe_reg    <= lanePe_next;
         diffSwing_reg <= diffSwing_next;
         rdData_reg    <= rdData_next;
         divLive_reg   <= divLive_next;
      end
   end

   // ------------------------------------------------------------
   // Field outputs
   // ------------------------------------------------------------
   assign regRdData           = rdData_reg;
   assign regHit              = addrHit(regAddr);
   assign vDivSel             = fbDivVp_reg[csdoc_pkg::V_DIV_LSB +: 2];
   assign pDivSel             = fbDivVp_reg[csdoc_pkg::P_DIV_LSB +: 2];
   assign nDivSel             = fbDivN_reg[csdoc_pkg::N_DIV_LSB +: 6];
   assign oscillatorBiasLevel = oscBias_reg[csdoc_pkg::BIAS_LSB +: 7];
   assign biasNotRecommended  = oscillatorBiasLevel != csdoc_pkg::OSC_BIAS_IN_USE;
   assign lanePreemphasis     = lanePe_reg[csdoc_pkg::PE_LSB +: 4];
   assign outputSwingSel      = diffSwing_reg[csdoc_pkg::SWING_LSB +: 2];
   assign highSwingSetting    = outputSwingSel == 2'h0;
   assign divChangedLive      = divLive_reg;

   csdoc_ratio_decode u_decode (
      .vSel        (vDivSel),
      .pSel        (pDivSel),
      .nSel        (nDivSel),
      .vRatio      (vDivRatio),
      .pRatio      (pDivRatio),
      .nRatio      (nDivRatio),
      .selReserved (divSelReserved)
   );

   // VCO to sampling clock ratio is V times P; N then divides the sampling clock
   assign samplingRatio = {3'h0, 6'(vDivRatio * pDivRatio)};

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   sequence s_write_vp;
      regWrEn && regAddr == csdoc_pkg::ADDR_FB_DIV_VP;
   endsequence

   sequence s_write_n;
      regWrEn && regAddr == csdoc_pkg::ADDR_FB_DIV_N;
   endsequence

   sequence s_write_bias;
      regWrEn && regAddr == csdoc_pkg::ADDR_OSC_BIAS;
   endsequence

   sequence s_write_pe;
      regWrEn && regAddr == csdoc_pkg::ADDR_LANE_PE;
   endsequence

   sequence s_write_swing;
      regWrEn && regAddr == csdoc_pkg::ADDR_DIFF_SWING;
   endsequence

   // A divider write while the synthesizer runs is a software fault worth flagging
   sequence s_live_div_write;
      regWrEn && !synthPllReset
      && (regAddr == csdoc_pkg::ADDR_FB_DIV_VP || regAddr == csdoc_pkg::ADDR_FB_DIV_N);
   endsequence

   a_vp_write_store: assert property (@(posedge mclk) disable iff (!rst_n)
      s_write_vp |=> fbDivVp_reg == $past(regWrData))
      else $error("V/P register did not store write");
   a_v_ratio_map: assert property (@(posedge mclk) disable iff (!rst_n)
      vDivSel == 2'h0 |-> vDivRatio == 3'h5)
      else $error("V code 0 not divide by 5");
   a_p_ratio_map: assert property (@(posedge mclk) disable iff (!rst_n)
      pDivSel == 2'h2 |-> pDivRatio == 3'h4)
      else $error("P code 2 not divide by 4");
   a_sample_ratio: assert property (@(posedge mclk) disable iff (!rst_n)
      vDivSel == 2'h2 && pDivSel == 2'h1 |-> samplingRatio == 9'h006)
      else $error("Sampling ratio wrong");
   a_n_ratio_value: assert property (@(posedge mclk) disable iff (!rst_n)
      s_write_n |=> nDivRatio == $past(regWrData[5:0]))
      else $error("N ratio does not follow write");
   a_n_write_store: assert property (@(posedge mclk) disable iff (!rst_n)
      regWrEn && regAddr == csdoc_pkg::ADDR_FB_DIV_N |=> nDivSel == $past(regWrData[5:0]))
      else $error("N field did not store write");
   a_pe_hold_value: assert property (@(posedge mclk) disable iff (!rst_n)
      !(regWrEn && regAddr == csdoc_pkg::ADDR_LANE_PE) |=> $stable(lanePreemphasis))
      else $error("Pre-emphasis changed without write");
   a_swing_high_sel: assert property (@(posedge mclk) disable iff (!rst_n)
      s_write_swing |=> highSwingSetting == ($past(regWrData[1:0]) == 2'h0))
      else $error("High swing flag wrong");
   a_read_back: assert property (@(posedge mclk) disable iff (!rst_n)
      regAddr == csdoc_pkg::ADDR_OSC_BIAS ##1 1'b1 |-> regRdData == $past(oscBias_reg))
      else $error("Bias readback wrong");
   a_bias_write_store: assert property (@(posedge mclk) disable iff (!rst_n)
      s_write_bias |=> oscBias_reg == $past(regWrData))
      else $error("Bias register did not store write");
   a_pe_write_store: assert property (@(posedge mclk) disable iff (!rst_n)
      s_write_pe |=> lanePe_reg == $past(regWrData))
      else $error("Pre-emphasis register did not store write");
   a_swing_write_store: assert property (@(posedge mclk) disable iff (!rst_n)
      s_write_swing |=> diffSwing_reg == $past(regWrData))
      else $error("Swing register did not store write");
   a_vp_hold_value: assert property (@(posedge mclk) disable iff (!rst_n)
      !(regWrEn && regAddr == csdoc_pkg::ADDR_FB_DIV_VP) |=> $stable(fbDivVp_reg))
      else $error("V/P register changed without write");
   a_n_hold_value: assert property (@(posedge mclk) disable iff (!rst_n)
      !(regWrEn && regAddr == csdoc_pkg::ADDR_FB_DIV_N) |=> $stable(fbDivN_reg))
      else $error("N register changed without write");
   a_live_flag_set: assert property (@(posedge mclk) disable iff (!rst_n)
      s_live_div_write |=> divChangedLive)
      else $error("Live divider change not flagged");
   a_live_flag_clear: assert property (@(posedge mclk) disable iff (!rst_n)
      synthPllReset |=> !divChangedLive)
      else $error("Live change flag not cleared by synthesizer reset");
   a_unmapped_read_zero: assert property (@(posedge mclk) disable iff (!rst_n)
      !regHit |=> regRdData == 8'h00)
      else $error("Unmapped read not zero");
   a_v_reserved_flag: assert property (@(posedge mclk) disable iff (!rst_n)
      vDivSel == 2'h3 |-> divSelReserved && vDivRatio == 3'h0)
      else $error("V reserved code not flagged");
   a_p_reserved_flag: assert property (@(posedge mclk) disable iff (!rst_n)
      pDivSel == 2'h3 |-> divSelReserved && pDivRatio == 3'h0)
      else $error("P reserved code not flagged");
   a_p_code1_map: assert property (@(posedge mclk) disable iff (!rst_n)
      pDivSel == 2'h1 |-> pDivRatio == 3'h2)
      else $error("P code 1 not divide by 2");
   a_n_zero_flag: assert property (@(posedge mclk) disable iff (!rst_n)
      nDivSel == 6'h00 |-> divSelReserved)
      else $error("N ratio zero not flagged");
endmodule

// file: sim/csdoc_cfg_regs_tb.sv
`timescale 1ns/1ps
module csdoc_cfg_regs_tb;
   logic       mclk;
   logic       rst_n;
   logic       regWrEn;
   logic       synthPllReset;
   logic [7:0] regAddr;
   logic [7:0] regWrData;
   logic [7:0] regRdData;
   logic       regHit, divSelReserved, divChangedLive, biasNotRecommended, highSwingSetting;
   logic [1:0] vDivSel, pDivSel, outputSwingSel;
   logic [5:0] nDivSel, nDivRatio;
   logic [2:0] vDivRatio, pDivRatio;
   logic [8:0] samplingRatio;
   logic [6:0] oscillatorBiasLevel;
   logic [3:0] lanePreemphasis;
   logic [2:0] vTab [4];
   logic [2:0] pTab [4];
   logic [7:0] nVals [4];
   int         errors;
   int         num_checks;

   csdoc_cfg_regs DUT (
      .mclk(mclk), .rst_n(rst_n), .regWrEn(regWrEn), .regAddr(regAddr), .regWrData(regWrData),
      .synthPllReset(synthPllReset), .regRdData(regRdData), .regHit(regHit), .vDivSel(vDivSel),
      .pDivSel(pDivSel), .nDivSel(nDivSel), .vDivRatio(vDivRatio), .pDivRatio(pDivRatio),
      .nDivRatio(nDivRatio), .samplingRatio(samplingRatio), .divSelReserved(divSelReserved),
      .divChangedLive(divChangedLive), .oscillatorBiasLevel(oscillatorBiasLevel),
      .biasNotRecommended(biasNotRecommended), .lanePreemphasis(lanePreemphasis),
      .outputSwingSel(outputSwingSel), .highSwingSetting(highSwingSetting)
   );

   // ------------------------------------------------------------
   // Checking and access tasks
   // ------------------------------------------------------------
   task automatic results();
      if (errors == 0 && num_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic chk(input string n, input logic [8:0] e, input logic [8:0] g);
      num_checks++;
      if (g !== e) begin
         $display("unexpected %s expected %h seen %h", n, e, g);
         errors++;
      end
   endtask

   // Strobe stays high so back-to-back writes never toggle it within one step
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      regWrEn = 1'b1;
      regAddr = a;
      regWrData = d;
      @(posedge mclk);
      #1;
   endtask

   task automatic idle();
      regWrEn = 1'b0;
      @(posedge mclk);
      #1;
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic h);
      regWrEn = 1'b0;
      regAddr = a;
      @(posedge mclk);
      #1;
      chk("regRdData", {1'b0, e}, {1'b0, regRdData});
      chk("regHit", {8'h00, h}, {8'h00, regHit});
   endtask

   task automatic doRst();
      regWrEn = 1'b0;
      rst_n = 1'b0;
      repeat (8) @(posedge mclk);
      #1 rst_n = 1'b1;
   endtask

   task automatic chkReset();
      rd(8'h3D, 8'h00, 1'b1);
      rd(8'h3E, 8'h20, 1'b1);
      rd(8'h3F, 8'h4F, 1'b1);
      rd(8'h48, 8'h00, 1'b1);
      rd(8'h50, 8'h00, 1'b1);
      chk("samplingRatio", 9'h005, samplingRatio);
      chk("highSwingSetting", 9'h001, {8'h00, highSwingSetting});
      chk("divChangedLive", 9'h000, {8'h00, divChangedLive});
      chk("oscillatorBiasLevel", 9'h04F, {2'h0, oscillatorBiasLevel});
      chk("biasNotRecommended", 9'h001, {8'h00, biasNotRecommended});
      chk("nDivSel", 9'h020, {3'h0, nDivSel});
   endtask

   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   // Hang guard
   initial begin
      repeat (20000) @(posedge mclk);
      errors++;
      results();
   end

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      rst_n = 1'b0;
      regWrEn = 1'b0;
      regAddr = 8'h00;
      regWrData = 8'h00;
      synthPllReset = 1'b1;
      errors = 0;
      num_checks = 0;
      vTab = '{3'h5, 3'h4, 3'h3, 3'h0};
      pTab = '{3'h1, 3'h2, 3'h4, 3'h0};
      nVals = '{8'h01, 8'h3F, 8'h00, 8'h20};
      doRst();
      chkReset();
      // Every first and second stage code, reserved ones included
      for (int i = 0; i < 16; i++) begin
         wr(8'h3D, 8'(i));
         chk("vDivRatio", {6'h00, vTab[i[1:0]]}, {6'h00, vDivRatio});
         chk("pDivRatio", {6'h00, pTab[i[3:2]]}, {6'h00, pDivRatio});
         chk("samplingRatio", {6'h00, vTab[i[1:0]]} * {6'h00, pTab[i[3:2]]}, samplingRatio);
         chk("divSelReserved", {8'h00, i[1:0] == 2'h3 || i[3:2] == 2'h3}, {8'h00, divSelReserved});
         chk("vDivSel", {7'h00, i[1:0]}, {7'h00, vDivSel});
         chk("pDivSel", {7'h00, i[3:2]}, {7'h00, pDivSel});
         rd(8'h3D, 8'(i), 1'b1);
      end
      wr(8'h3D, 8'h06);
      for (int i = 0; i < 4; i++) begin
         wr(8'h3E, nVals[i]);
         chk("nDivRatio", {1'b0, nVals[i]}, {3'h0, nDivRatio});
         chk("divSelReserved", {8'h00, nVals[i] == 8'h00}, {8'h00, divSelReserved});
         chk("nDivSel", {1'b0, nVals[i]}, {3'h0, nDivSel});
         rd(8'h3E, nVals[i], 1'b1);
      end
      // Back to back writes of bias, pre-emphasis and swing
      wr(8'h3F, 8'h4A);
      wr(8'h48, 8'h0F);
      wr(8'h50, 8'h02);
      rd(8'h3F, 8'h4A, 1'b1);
      chk("biasNotRecommended", 9'h000, {8'h00, biasNotRecommended});
      chk("oscillatorBiasLevel", 9'h04A, {2'h0, oscillatorBiasLevel});
      chk("lanePreemphasis", 9'h00F, {5'h00, lanePreemphasis});
      for (int c = 0; c < 4; c++) begin
         wr(8'h50, 8'(c));
         chk("highSwingSetting", {8'h00, c == 0}, {8'h00, highSwingSetting});
         chk("outputSwingSel", 9'(c), {7'h00, outputSwingSel});
      end
      // Unmapped place: write ignored, read returns zero
      wr(8'h40, 8'h55);
      rd(8'h40, 8'h00, 1'b0);
      rd(8'h48, 8'h0F, 1'b1);
      // Divider change while the synthesizer runs is flagged
      synthPllReset = 1'b0;
      wr(8'h48, 8'h05);
      idle();
      chk("divChangedLive", 9'h000, {8'h00, divChangedLive});
      wr(8'h3E, 8'h20);
      idle();
      chk("divChangedLive", 9'h001, {8'h00, divChangedLive});
      synthPllReset = 1'b1;
      idle();
      chk("divChangedLive", 9'h000, {8'h00, divChangedLive});
      doRst();
      chkReset();
      results();
   end
endmodule
